/* File: scp_cfg_byte.sv */
`timescale 1ns/1ps
module scp_cfg_byte #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] DEFAULT = '0
) (
  input wire logic clk_sys,
  input wire logic clr,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic update,
  output logic [WIDTH-1:0] buf_q,
  output logic [WIDTH-1:0] act_q
);

  // ----------------------------------------
  // Shadow copy and live copy
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (clr) begin
      buf_q <= DEFAULT;
    end else if (wr_en) begin
      buf_q <= wr_data;
    end
  end

  // Live copy follows only on update, so many writes land together
  always_ff @(posedge clk_sys) begin
    if (clr) begin
      act_q <= DEFAULT;
    end else if (update) begin
      act_q <= buf_q;
    end
  end

endmodule // scp_cfg_byte

/* File: scp_defines.svh */
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SCP_ADDR_PORT_CFG 13'h000
`define SCP_ADDR_RB_SEL 13'h004
`define SCP_ADDR_PLL_CFG 13'h010
`define SCP_ADDR_LVPECL0 13'h0F0
`define SCP_ADDR_DIST 13'h230
`define SCP_ADDR_UPDATE 13'h232

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCP_BIT_SDO_EN_HI 7
`define SCP_BIT_SDO_EN_LO 0
`define SCP_BIT_LSB_HI 6
`define SCP_BIT_LSB_LO 1
`define SCP_BIT_SOFT_HI 5
`define SCP_BIT_SOFT_LO 2
`define SCP_BIT_DIST_PD 1
`define SCP_BIT_UPDATE 0
`define SCP_BIT_RB_ACTIVE 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SCP_DEF_PORT_CFG 8'h18
`define SCP_KEEP_SOFT_MASK 8'h24
`define SCP_DEF_RB_SEL 8'h00
`define SCP_DEF_PLL_CFG 8'h00
`define SCP_DEF_LVPECL 8'h00
`define SCP_DEF_DIST 8'h00
`define SCP_DEF_PECL_CODE 2'h0

// ----------------------------------------
// Codes
// ----------------------------------------
`define SCP_PLL_ASYNC_PD 2'h1
`define SCP_PLL_SYNC_PD 2'h3
`define SCP_PECL_SAFE_OFF 2'h2
`define SCP_LEN_STREAM 2'h3
`define SCP_INSTR_LAST 4'hF
`define SCP_BYTE_LAST 3'h7

`endif

/* File: scp_host_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Serial master model
// ----------------------------------------
module scp_host_model (
  input wire logic clk_sys,
  output logic sclk,
  output logic cs_n,
  output logic sdio_i,
  input wire logic sdio_o,
  input wire logic sdio_oe,
  input wire logic rb_o,
  input wire logic rb_oe
);
  logic drv;
  logic last;
  logic uni;
  logic oe_bad;
  logic cs_q;
  logic cs_q2;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    drv = 1'b0;
    last = 1'b0;
    uni = 1'b0;
    oe_bad = 1'b0;
  end

  // Released pin shows the inverse, so a stale value never passes
  always_comb sdio_i = sdio_oe ? sdio_o : (drv ? last : ~last);

  // Sampled select lags the pin, so allow two cycles
  always @(posedge clk_sys) begin
    cs_q <= cs_n;
    cs_q2 <= cs_q;
    if (cs_n && cs_q && cs_q2 && (sdio_oe || rb_oe)) begin
      oe_bad <= 1'b1;
    end
  end

  // Four clk_sys cycles per sclk phase
  task automatic tick();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  // Set data with sclk low, both sides sample on the rise
  task automatic bit_io(input logic d, output logic q);
    sclk = 1'b0;
    last = d;
    tick();
    sclk = 1'b1;
    if (uni) begin
      q = rb_oe ? rb_o : 1'bx;
    end else begin
      q = sdio_oe ? sdio_o : 1'bx;
    end
    tick();
  endtask

  // Byte boundary at brk stalls, elsewhere it ends the frame
  task automatic xfer(input logic [15:0] ins, input int nb, input logic [31:0] wd,
                      input int brk, output logic [31:0] rd);
    logic q;
    logic [47:0] sh;
    int i;
    sh = {ins, wd};
    rd = '0;
    drv = 1'b1;
    cs_n = 1'b0;
    tick();
    for (i = 0; i < 16 + 8 * nb; i++) begin
      if (i == brk) begin
        sclk = 1'b0;
        cs_n = 1'b1;
        tick();
        tick();
        if (i % 8 != 0) begin
          break;
        end
        cs_n = 1'b0;
        tick();
      end
      drv = !(ins[15] && i >= 16);
      bit_io(sh[47 - i], q);
      if (i >= 16) begin
        rd = {rd[30:0], q};
      end
    end
    sclk = 1'b0;
    tick();
    cs_n = 1'b1;
    drv = 1'b0;
    tick();
  endtask
endmodule // scp_host_model

/* File: scp_pkg.sv */
package scp_pkg;

  typedef enum logic [2:0] {
    scp_idle,
    scp_instr,
    scp_data,
    scp_stall,
    scp_done
  } scp_state_t;

  typedef struct packed {
    logic rw;
    logic [1:0] len;
    logic [12:0] addr;
  } scp_instr_t;

  typedef struct packed {
    logic pll_off;
    logic vco_off;
    logic clkin_off;
    logic div_off;
    logic lvds_cmos_off;
    logic dist_off;
  } scp_pwr_t;

endpackage

/* File: scp_serial_ctrl.sv */
`timescale 1ns/1ps
`include "scp_defines.svh"
module scp_serial_ctrl #(
  parameter int N_LVPECL = 6
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic reset_pin_n,
  input wire logic sleep_request_pin_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe,
  output logic readback_output_pin_o,
  output logic readback_output_pin_oe,
  input wire logic cp_event,
  output scp_pkg::scp_pwr_t pwr,
  output logic [N_LVPECL-1:0][1:0] lvpecl_mode,
  output logic align_request,
  output logic wake_realign_hint
);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (N_LVPECL < 1 || N_LVPECL > 6) begin : g_bad_count
    $error("N_LVPECL must be 1 to 6");
  end

  // ----------------------------------------
  // Resets and port configuration
  // ----------------------------------------
  logic hard_rst;
  logic soft_rst;
  logic soft_q;
  logic reg_clr;
  logic port_rst;
  logic [7:0] port_cfg;
  logic lsb_first;
  logic sdo_en;
  logic wr_stb;
  logic [12:0] wr_addr;
  logic [7:0] wr_data;
  logic upd;

  assign hard_rst = srst | ~reset_pin_n;
  assign soft_rst = port_cfg[`SCP_BIT_SOFT_HI] | port_cfg[`SCP_BIT_SOFT_LO];
  assign reg_clr = hard_rst | soft_rst;
  assign port_rst = hard_rst | (soft_rst & ~soft_q);
  assign lsb_first = port_cfg[`SCP_BIT_LSB_HI] | port_cfg[`SCP_BIT_LSB_LO];
  assign sdo_en = port_cfg[`SCP_BIT_SDO_EN_HI] | port_cfg[`SCP_BIT_SDO_EN_LO];

  always_ff @(posedge clk_sys) begin
    if (hard_rst) begin
      soft_q <= 1'b0;
    end else begin
      soft_q <= soft_rst;
    end
  end

  // Mirrored port bits act at once; soft bits survive their own reset
  always_ff @(posedge clk_sys) begin
    if (hard_rst) begin
      port_cfg <= `SCP_DEF_PORT_CFG;
    end else if (wr_stb && wr_addr == `SCP_ADDR_PORT_CFG) begin
      port_cfg <= wr_data;
    end else if (soft_rst) begin
      port_cfg <= `SCP_DEF_PORT_CFG | (port_cfg & `SCP_KEEP_SOFT_MASK);
    end
  end

  // Self-clearing: the bit itself is never stored, reads as zero
  always_ff @(posedge clk_sys) begin
    if (reg_clr) begin
      upd <= 1'b0;
    end else begin
      upd <= wr_stb && wr_addr == `SCP_ADDR_UPDATE && wr_data[`SCP_BIT_UPDATE];
    end
  end

  // ----------------------------------------
  // Buffered configuration registers
  // ----------------------------------------
  logic [7:0] rb_buf, rb_act, pll_buf, pll_act, dist_buf, dist_act;
  logic [N_LVPECL-1:0][7:0] pecl_buf, pecl_act;

  // Sleep is not among the clears, so contents ride through it
  scp_cfg_byte #(.WIDTH(8), .DEFAULT(`SCP_DEF_RB_SEL)) u_rb_sel (
    .clk_sys(clk_sys), .clr(reg_clr), .wr_en(wr_stb && wr_addr == `SCP_ADDR_RB_SEL),
    .wr_data(wr_data), .update(upd), .buf_q(rb_buf), .act_q(rb_act)
  );
  scp_cfg_byte #(.WIDTH(8), .DEFAULT(`SCP_DEF_PLL_CFG)) u_pll (
    .clk_sys(clk_sys), .clr(reg_clr), .wr_en(wr_stb && wr_addr == `SCP_ADDR_PLL_CFG),
    .wr_data(wr_data), .update(upd), .buf_q(pll_buf), .act_q(pll_act)
  );
  scp_cfg_byte #(.WIDTH(8), .DEFAULT(`SCP_DEF_DIST)) u_dist (
    .clk_sys(clk_sys), .clr(reg_clr), .wr_en(wr_stb && wr_addr == `SCP_ADDR_DIST),
    .wr_data(wr_data), .update(upd), .buf_q(dist_buf), .act_q(dist_act)
  );

  for (genvar i = 0; i < N_LVPECL; i++) begin : g_pecl
    scp_cfg_byte #(.WIDTH(8), .DEFAULT(`SCP_DEF_LVPECL)) u_pecl (
      .clk_sys(clk_sys), .clr(reg_clr),
      .wr_en(wr_stb && wr_addr == `SCP_ADDR_LVPECL0 + 13'(i)),
      .wr_data(wr_data), .update(upd), .buf_q(pecl_buf[i]), .act_q(pecl_act[i])
    );
  end

  // Unmapped or out-of-range addresses read zero
  function automatic logic [7:0] rd_byte(input logic [12:0] a);
    logic [7:0] v;
    logic sel;
    v = 8'h00;
    sel = rb_act[`SCP_BIT_RB_ACTIVE];
    if (a == `SCP_ADDR_PORT_CFG) v = port_cfg;
    if (a == `SCP_ADDR_RB_SEL) v = sel ? rb_act : rb_buf;
    if (a == `SCP_ADDR_PLL_CFG) v = sel ? pll_act : pll_buf;
    if (a == `SCP_ADDR_DIST) v = sel ? dist_act : dist_buf;
    for (int k = 0; k < N_LVPECL; k++) begin
      if (a == `SCP_ADDR_LVPECL0 + 13'(k)) v = sel ? pecl_act[k] : pecl_buf[k];
    end
    return v;
  endfunction

  // ----------------------------------------
  // Serial port sequencing
  // ----------------------------------------
  scp_pkg::scp_state_t state;
  scp_pkg::scp_instr_t ins;
  logic sclk_q, cs_q;
  logic sclk_rise, sclk_fall, cs_rise, cs_fall;
  logic [3:0] bit_cnt;
  logic boundary;
  logic resume_data;
  logic [1:0] bytes_left;
  logic [12:0] addr;
  logic [12:0] next_addr;
  logic [15:0] sh;
  logic [15:0] next_sh;
  logic [7:0] next_db;
  logic [7:0] rd_shift;
  logic out_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
    end else begin
      sclk_q <= sclk;
      cs_q <= cs_n;
    end
  end

  assign sclk_rise = sclk & ~sclk_q & ~cs_n;
  assign sclk_fall = ~sclk & sclk_q & ~cs_n;
  assign cs_rise = cs_n & ~cs_q;
  assign cs_fall = ~cs_n & cs_q;
  assign boundary = bit_cnt[2:0] == 3'h0;
  assign next_sh = lsb_first ? {sdio_i, sh[15:1]} : {sh[14:0], sdio_i};
  assign next_db = next_sh[15:8] & {8{lsb_first}} | next_sh[7:0] & {8{~lsb_first}};
  assign next_addr = lsb_first ? addr + 13'h0001 : addr - 13'h0001;

  always_ff @(posedge clk_sys) begin
    if (port_rst) begin
      state <= scp_pkg::scp_idle;
      bit_cnt <= 4'h0;
      resume_data <= 1'b0;
    end else begin
      unique case (state)
        scp_pkg::scp_idle: begin
          bit_cnt <= 4'h0;
          resume_data <= 1'b0;
          if (cs_fall) state <= scp_pkg::scp_instr;
        end
        scp_pkg::scp_instr: begin
          if (cs_rise) begin
            state <= boundary ? scp_pkg::scp_stall : scp_pkg::scp_idle;
          end else if (sclk_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == `SCP_INSTR_LAST) begin
              state <= scp_pkg::scp_data;
              resume_data <= 1'b1;
            end
          end
        end
        scp_pkg::scp_data: begin
          if (cs_rise) begin
            if (!boundary) state <= scp_pkg::scp_idle;
            else if (ins.len == `SCP_LEN_STREAM) state <= scp_pkg::scp_idle;
            else state <= scp_pkg::scp_stall;
          end else if (sclk_rise) begin
            bit_cnt <= {1'b0, bit_cnt[2:0] + 3'h1};
            if (bit_cnt[2:0] == `SCP_BYTE_LAST && ins.len != `SCP_LEN_STREAM
                && bytes_left == 2'h0) begin
              state <= scp_pkg::scp_done;
            end
          end
        end
        scp_pkg::scp_stall: begin
          if (cs_fall) state <= resume_data ? scp_pkg::scp_data : scp_pkg::scp_instr;
        end
        scp_pkg::scp_done: begin
          if (cs_rise) state <= scp_pkg::scp_idle;
        end
      endcase
    end
  end

  // Instruction and data capture; write strobe is one cycle per byte
  always_ff @(posedge clk_sys) begin
    if (port_rst) begin
      sh <= 16'h0000;
      ins <= '0;
      addr <= 13'h0000;
      bytes_left <= 2'h0;
      wr_stb <= 1'b0;
      wr_addr <= 13'h0000;
      wr_data <= 8'h00;
      rd_shift <= 8'h00;
      out_q <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      if (state == scp_pkg::scp_instr && sclk_rise && !cs_rise) begin
        sh <= next_sh;
        if (bit_cnt == `SCP_INSTR_LAST) begin
          ins <= next_sh;
          addr <= next_sh[12:0];
          bytes_left <= next_sh[14:13];
          rd_shift <= rd_byte(next_sh[12:0]);
        end
      end else if (state == scp_pkg::scp_data && sclk_rise && !cs_rise) begin
        sh <= next_sh;
        if (bit_cnt[2:0] == `SCP_BYTE_LAST) begin
          wr_stb <= ~ins.rw;
          wr_addr <= addr;
          wr_data <= next_db;
          addr <= next_addr;
          bytes_left <= bytes_left - 2'h1;
          rd_shift <= rd_byte(next_addr);
        end
      end else if (state == scp_pkg::scp_data && sclk_fall && ins.rw) begin
        out_q <= lsb_first ? rd_shift[0] : rd_shift[7];
        rd_shift <= lsb_first ? {1'b0, rd_shift[7:1]} : {rd_shift[6:0], 1'b0};
      end
    end
  end

  // Pins float whenever select is high or no read is under way
  always_comb begin
    sdio_oe = ~cs_n && state == scp_pkg::scp_data && ins.rw && ~sdo_en;
    readback_output_pin_oe = ~cs_n && state == scp_pkg::scp_data && ins.rw && sdo_en;
  end
  assign sdio_o = out_q;
  assign readback_output_pin_o = out_q;

  // ----------------------------------------
  // Power-down control
  // ----------------------------------------
  logic sleep_q;
  logic por_q;

  always_ff @(posedge clk_sys) begin
    if (reg_clr) begin
      pwr.pll_off <= 1'b0;
    end else if (!sleep_request_pin_n) begin
      pwr.pll_off <= 1'b1;
    end else if (pll_act[1:0] == `SCP_PLL_ASYNC_PD) begin
      pwr.pll_off <= 1'b1;
    end else if (pll_act[1:0] == `SCP_PLL_SYNC_PD) begin
      if (cp_event) pwr.pll_off <= 1'b1;
    end else begin
      pwr.pll_off <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reg_clr) begin
      pwr.vco_off <= 1'b0;
      pwr.clkin_off <= 1'b0;
      pwr.div_off <= 1'b0;
      pwr.lvds_cmos_off <= 1'b0;
      pwr.dist_off <= 1'b0;
    end else begin
      pwr.vco_off <= ~sleep_request_pin_n;
      pwr.clkin_off <= ~sleep_request_pin_n;
      pwr.div_off <= ~sleep_request_pin_n;
      pwr.lvds_cmos_off <= ~sleep_request_pin_n;
      pwr.dist_off <= dist_act[`SCP_BIT_DIST_PD];
    end
  end

  // Same code holds under distribution power-down; sleep forces safe-off
  for (genvar j = 0; j < N_LVPECL; j++) begin : g_pecl_pd
    always_ff @(posedge clk_sys) begin
      if (reg_clr) begin
        lvpecl_mode[j] <= `SCP_DEF_PECL_CODE;
      end else if (!sleep_request_pin_n) begin
        lvpecl_mode[j] <= `SCP_PECL_SAFE_OFF;
      end else begin
        lvpecl_mode[j] <= pecl_act[j][1:0];
      end
    end
  end

  // Wake keeps calibration; only alignment may be wanted again
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sleep_q <= 1'b1;
      wake_realign_hint <= 1'b0;
    end else begin
      sleep_q <= sleep_request_pin_n;
      wake_realign_hint <= sleep_request_pin_n & ~sleep_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    por_q <= srst;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      align_request <= 1'b0;
    end else begin
      align_request <= por_q;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  pins_float_a:
    assert property (cs_n |-> !sdio_oe && !readback_output_pin_oe)
    else $error("data pin driven while select high");
  rb_pin_mode_a:
    assert property (readback_output_pin_oe |-> sdo_en && !sdio_oe)
    else $error("readback pin driven outside unidirectional mode");
  sleep_off_a:
    assert property (!sleep_request_pin_n && reset_pin_n && !soft_rst
      |=> pwr.pll_off && pwr.vco_off && pwr.div_off && lvpecl_mode[0] == 2'h2)
    else $error("sleep did not power down");
  async_pd_a:
    assert property (pll_act[1:0] == 2'h1 && reset_pin_n && !soft_rst |=> pwr.pll_off)
    else $error("async power-down late");
  sync_pd_a:
    assert property (pll_act[1:0] == 2'h3 && !cp_event && !pwr.pll_off
      && sleep_request_pin_n && reset_pin_n && !soft_rst |=> !pwr.pll_off)
    else $error("sync power-down before charge pump event");
  dist_pd_a:
    assert property (dist_act[1] && reset_pin_n && !soft_rst |=> pwr.dist_off)
    else $error("distribution bias not off");
  soft_def_a:
    assert property (soft_rst |=> pll_act == 8'h00 && dist_act == 8'h00)
    else $error("soft reset left non-default value");
  por_align_a:
    assert property ($fell(srst) |=> align_request ##1 !align_request)
    else $error("no single alignment after power-on");
  nonbyte_abort_a:
    assert property (state == scp_pkg::scp_data && cs_rise && bit_cnt[2:0] != 3'h0
      && !port_rst |=> state == scp_pkg::scp_idle)
    else $error("non-boundary rise did not abort");
  instr_len_a:
    assert property (state == scp_pkg::scp_instr && sclk_rise && !cs_rise && !port_rst
      && bit_cnt == 4'hF |=> state == scp_pkg::scp_data && bit_cnt == 4'h0)
    else $error("data phase not after sixteen bits");

endmodule // scp_serial_ctrl

/* File: scp_serial_ctrl_tb.sv */
`timescale 1ns/1ps
module scp_serial_ctrl_tb;
  logic clk_sys, srst, reset_pin_n, sleep_request_pin_n, cp_event;
  logic sclk, cs_n, sdio_i, sdio_o, sdio_oe, rb_o, rb_oe;
  logic align_request, wake_realign_hint;
  scp_pkg::scp_pwr_t pwr;
  logic [5:0][1:0] lvpecl_mode;
  logic [31:0] rd;
  int err_count, total_checks, aligns, hints;

  scp_serial_ctrl #(.N_LVPECL(6)) scp_serial_ctrl_inst (
    .clk_sys(clk_sys), .srst(srst), .reset_pin_n(reset_pin_n),
    .sleep_request_pin_n(sleep_request_pin_n), .sclk(sclk), .cs_n(cs_n),
    .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe(sdio_oe),
    .readback_output_pin_o(rb_o), .readback_output_pin_oe(rb_oe),
    .cp_event(cp_event), .pwr(pwr), .lvpecl_mode(lvpecl_mode),
    .align_request(align_request), .wake_realign_hint(wake_realign_hint)
  );

  scp_host_model scp_host_model_inst (
    .clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_i), .sdio_o(sdio_o),
    .sdio_oe(sdio_oe), .rb_o(rb_o), .rb_oe(rb_oe)
  );

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (align_request === 1'b1) aligns <= aligns + 1;
    if (wake_realign_hint === 1'b1) hints <= hints + 1;
  end

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      err_count++;
    end
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    scp_host_model_inst.xfer({3'b000, a}, 1, {d, 24'h0}, -1, rd);
  endtask

  task automatic rdb(input logic [12:0] a);
    scp_host_model_inst.xfer({3'b100, a}, 1, 32'h0, -1, rd);
  endtask

  task automatic upd();
    wr(13'h232, 8'h01);
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  task automatic done(input string name);
    $display("Test %s done", name);
  endtask

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Whole run is near 9000 cycles
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    finish_test();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    err_count = 0;
    total_checks = 0;
    aligns = 0;
    hints = 0;
    srst = 1'b1;
    reset_pin_n = 1'b1;
    sleep_request_pin_n = 1'b1;
    cp_event = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    chk(aligns, 1, "align");
    chk({pwr, lvpecl_mode}, 0, "defaults");
    done("reset");
    wr(13'h0F0, 8'h02);
    rdb(13'h0F0);
    chk(rd[1:0], 2'b10, "readback");
    chk(lvpecl_mode, 0, "buffered");
    upd();
    chk(lvpecl_mode[0], 2'b10, "code 10");
    done("single");
    scp_host_model_inst.xfer({3'b001, 13'h0F1}, 2, 32'h0203_0000, -1, rd);
    scp_host_model_inst.xfer({3'b101, 13'h0F1}, 2, 32'h0, -1, rd);
    chk({rd[9:8], rd[1:0]}, 4'hB, "two byte");
    upd();
    chk(lvpecl_mode[1:0], 4'hB, "codes 10 11");
    scp_host_model_inst.xfer({3'b011, 13'h0F2}, 3, 32'h0202_0000, -1, rd);
    upd();
    chk(lvpecl_mode[2:0], 6'h28, "stream");
    done("multi");
    wr(13'h000, 8'h5A);
    scp_host_model_inst.xfer(16'h4F04, 2, 32'hC040_0000, -1, rd);
    scp_host_model_inst.xfer(16'hCF01, 1, 32'h0, -1, rd);
    chk(rd[7:0], 8'h40, "lsb read");
    wr(13'h000, 8'h18);
    upd();
    chk(lvpecl_mode[3:2], 4'hB, "lsb codes");
    done("lsb");
    scp_host_model_inst.xfer({3'b010, 13'h0F5}, 3, 32'h0303_0300, 24, rd);
    upd();
    chk(lvpecl_mode[5:3], 6'h3F, "stall");
    scp_host_model_inst.xfer({3'b000, 13'h0F5}, 1, 32'h0, 19, rd);
    scp_host_model_inst.xfer({3'b000, 13'h0F4}, 1, 32'h0, 9, rd);
    upd();
    chk(lvpecl_mode[5:4], 4'hF, "abort");
    done("stall");
    wr(13'h230, 8'h02);
    upd();
    chk(pwr.dist_off, 1'b1, "dist");
    wr(13'h230, 8'h00);
    wr(13'h010, 8'h03);
    upd();
    chk(pwr.pll_off, 1'b0, "sync wait");
    cp_event = 1'b1;
    @(posedge clk_sys);
    #1;
    cp_event = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(pwr.pll_off, 1'b1, "sync pd");
    wr(13'h010, 8'h00);
    upd();
    chk(pwr, 0, "pll on");
    wr(13'h010, 8'h01);
    upd();
    chk(pwr.pll_off, 1'b1, "async pd");
    wr(13'h010, 8'h00);
    upd();
    done("power");
    sleep_request_pin_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk(pwr[5:1], 5'h1F, "sleep");
    chk(lvpecl_mode, 12'hAAA, "safe off");
    wr(13'h0F0, 8'h03);
    upd();
    rdb(13'h0F0);
    chk(rd[1:0], 2'b11, "sleep port");
    sleep_request_pin_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk(lvpecl_mode[0], 2'b11, "wake");
    chk(hints, 1, "realign");
    done("sleep");
    wr(13'h000, 8'h3C);
    repeat (3) @(posedge clk_sys);
    #1;
    chk(lvpecl_mode, 0, "soft");
    wr(13'h000, 8'h18);
    rdb(13'h0F5);
    chk(rd[1:0], 2'b00, "soft read");
    wr(13'h0F0, 8'h02);
    upd();
    reset_pin_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    reset_pin_n = 1'b1;
    @(posedge clk_sys);
    #1;
    chk(lvpecl_mode, 0, "pin reset");
    rdb(13'h0F0);
    chk(rd[1:0], 2'b00, "pin read");
    chk(aligns, 1, "one align");
    done("resets");
    wr(13'h0F5, 8'h03);
    wr(13'h000, 8'h99);
    scp_host_model_inst.uni = 1'b1;
    rdb(13'h0F5);
    chk(rd[1:0], 2'b11, "uni read");
    wr(13'h000, 8'h18);
    scp_host_model_inst.uni = 1'b0;
    rdb(13'h0F5);
    chk(rd[1:0], 2'b11, "bidir read");
    chk(scp_host_model_inst.oe_bad, 1'b0, "idle hiz");
    done("pins");
    finish_test();
  end
endmodule // scp_serial_ctrl_tb
